// [spi_port.sv]
// Serial peripheral port: master/slave shifter, pin drivers and boot strap decode
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"
module spi_port (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [1:0]                 boot_select_straps,
  input  wire logic [`SPC_CTL_W-1:0]      serial_port_control_register,
  input  wire logic [`SPC_DIV_W-1:0]      clk_div,
  input  wire logic                       tx_valid,
  input  wire spi_port_pkg::word_t        tx_word,
  output logic                            tx_ready,
  output logic                            rx_valid,
  output spi_port_pkg::word_t             rx_word,
  input  wire logic                       rx_ready,
  output logic                            multimaster_error,
  output spi_port_pkg::boot_mode_t        boot_mode,
  output logic                            busy,
  input  wire logic                       serial_bit_clock_pin_i,
  output logic                            serial_bit_clock_pin_o,
  output logic                            serial_bit_clock_pin_oe,
  input  wire logic                       mosi_i,
  output logic                            mosi_o,
  output logic                            mosi_oe,
  input  wire logic                       miso_i,
  output logic                            miso_o,
  output logic                            miso_oe,
  input  wire logic                       slave_select_input_n,
  output logic                            pullup_en
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] pins_raw;
  assign pins_raw = {serial_bit_clock_pin_i, mosi_i, miso_i, slave_select_input_n};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'hf;
      sync2_q <= 4'hf;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end
  logic sck_s, mosi_s, miso_s, ss_n_s;
  assign {sck_s, mosi_s, miso_s, ss_n_s} = sync2_q;
  logic [1:0] strap1_q;
  logic [1:0] strap2_q;
  // No reset: the straps must reach the pin drivers while reset is still low
  always_ff @(posedge sys_clk) begin
    strap1_q <= boot_select_straps;
    strap2_q <= strap1_q;
  end

  // ----------------------------------------
  // Boot strap capture after reset release
  // ----------------------------------------
  logic boot_caught_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_caught_q <= 1'b0;
      boot_mode     <= spi_port_pkg::BOOT_SPI_SLAVE;
    end else if (!boot_caught_q) begin
      boot_caught_q <= 1'b1;
      boot_mode     <= spi_port_pkg::boot_mode_t'(strap2_q); // RL14
    end
  end

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  logic is_master, cpol, cpha, od_sel, port_en, slv_tx_dis;
  assign is_master  = serial_port_control_register[`SPC_BIT_MASTER];
  assign cpol       = serial_port_control_register[`SPC_BIT_CPOL]; // RL4
  assign cpha       = serial_port_control_register[`SPC_BIT_CPHA]; // RL4
  assign od_sel     = serial_port_control_register[`SPC_BIT_OPEN_DRAIN];
  assign port_en    = serial_port_control_register[`SPC_BIT_ENABLE];
  assign slv_tx_dis = serial_port_control_register[`SPC_BIT_SLV_TX_DIS];
  logic slave_sel;
  assign slave_sel = port_en && !is_master && !ss_n_s; // RL7 RL2

  // ----------------------------------------
  // Two-entry transmit and receive buffers
  // ----------------------------------------
  logic [7:0] txb_q [2];
  logic [1:0] txc_q;
  logic       txr_q;
  logic       txw_q;
  logic       tx_pop;
  logic [7:0] rxb_q [2];
  logic [1:0] rxc_q;
  logic       rxr_q;
  logic       rxw_q;
  logic       rx_push;
  logic [7:0] rx_push_word;
  logic       tx_push;
  assign tx_push = tx_valid && tx_ready;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_q <= 2'h0;
      txr_q <= 1'b0;
      txw_q <= 1'b0;
      txb_q[0] <= 8'h00;
      txb_q[1] <= 8'h00;
      tx_ready <= 1'b0;
    end else begin
      if (tx_push) begin
        txb_q[txw_q] <= tx_word.data;
        txw_q <= ~txw_q;
      end
      if (tx_pop) txr_q <= ~txr_q;
      txc_q <= txc_q + {1'b0, tx_push} - {1'b0, tx_pop};
      tx_ready <= (txc_q + {1'b0, tx_push} - {1'b0, tx_pop}) < 2'h2;
    end
  end
  logic tx_have;
  assign tx_have = (txc_q != 2'h0);
  logic [7:0] tx_head;
  assign tx_head = txb_q[txr_q];
  logic rx_pop;
  assign rx_pop = rx_valid && rx_ready;
  logic rx_acc;
  assign rx_acc = rx_push && (rxc_q != 2'h2);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxc_q <= 2'h0;
      rxr_q <= 1'b0;
      rxw_q <= 1'b0;
      rxb_q[0] <= 8'h00;
      rxb_q[1] <= 8'h00;
      rx_valid <= 1'b0;
      rx_word <= '0;
    end else begin
      logic [1:0] n;
      logic       r;
      n = rxc_q + {1'b0, rx_acc} - {1'b0, rx_pop};
      r = rx_pop ? ~rxr_q : rxr_q;
      if (rx_acc) begin
        rxb_q[rxw_q] <= rx_push_word;
        rxw_q <= ~rxw_q;
      end
      rxr_q <= r;
      rxc_q <= n;
      rx_valid <= (n != 2'h0);
      rx_word.data <= (rx_acc && (rxc_q == 2'h0 || (rxc_q == 2'h1 && rx_pop))) ? rx_push_word : rxb_q[r];
    end
  end
  logic rx_room;
  assign rx_room = (rxc_q == 2'h0) || (rxc_q == 2'h1 && !rx_push);

  // ----------------------------------------
  // Master clock generator and shifter
  // ----------------------------------------
  spi_port_pkg::mst_state_t st_q;
  logic [`SPC_DIV_W-1:0] div_q;
  logic [`SPC_CNT_W-1:0] bit_q;
  logic [7:0]            msh_q;
  logic                  sck_q;
  logic                  mdo_q;
  logic                  m_done;
  logic                  tick;
  assign tick = (div_q == clk_div);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= spi_port_pkg::ST_IDLE;
      div_q <= '0;
      bit_q <= '0;
      msh_q <= 8'h00;
      sck_q <= 1'b0;
      mdo_q <= 1'b0;
    end else begin
      div_q <= (st_q == spi_port_pkg::ST_IDLE || tick) ? '0 : div_q + 1'b1;
      case (st_q)
        spi_port_pkg::ST_IDLE: begin
          sck_q <= cpol; // RL1
          if (port_en && is_master && ss_n_s && tx_have && rx_room) begin
            msh_q <= tx_head;
            mdo_q <= tx_head[7];
            bit_q <= '0;
            st_q  <= spi_port_pkg::ST_LEAD;
          end
        end
        spi_port_pkg::ST_LEAD: if (tick) begin
          sck_q <= ~cpol; // RL1
          if (cpha) mdo_q <= msh_q[7]; // RL3
          else msh_q <= {msh_q[6:0], miso_s}; // RL3
          st_q <= spi_port_pkg::ST_TRAIL;
        end
        spi_port_pkg::ST_TRAIL: if (tick) begin
          sck_q <= cpol;
          if (cpha) msh_q <= {msh_q[6:0], miso_s}; // RL3
          else mdo_q <= msh_q[7]; // RL3
          if (bit_q == `SPC_CNT_W'(`SPC_WORD_BITS - 1)) st_q <= spi_port_pkg::ST_IDLE;
          else begin
            bit_q <= bit_q + 1'b1;
            st_q  <= spi_port_pkg::ST_LEAD;
          end
        end
        default: st_q <= spi_port_pkg::ST_IDLE;
      endcase
    end
  end
  assign m_done = (st_q == spi_port_pkg::ST_TRAIL) && tick && (bit_q == `SPC_CNT_W'(`SPC_WORD_BITS - 1));

  // ----------------------------------------
  // Slave shifter on sampled bit clock edges
  // ----------------------------------------
  logic       sck_d1_q;
  logic [7:0] ssh_q;
  logic [`SPC_CNT_W-1:0] sbit_q;
  logic       sdo_q;
  logic       s_loaded_q;
  logic       s_done;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) sck_d1_q <= 1'b1;
    else sck_d1_q <= sck_s;
  end
  logic sck_edge, lead_edge;
  assign sck_edge  = slave_sel && (sck_s != sck_d1_q); // RL2
  assign lead_edge = (sck_s != cpol);
  logic s_sample;
  assign s_sample = sck_edge && (lead_edge ^ cpha);
  assign s_done = s_sample && (sbit_q == `SPC_CNT_W'(`SPC_WORD_BITS - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ssh_q <= 8'h00;
      sbit_q <= '0;
      sdo_q <= 1'b0;
      s_loaded_q <= 1'b0;
    end else if (!slave_sel) begin
      sbit_q <= '0;
      s_loaded_q <= 1'b0;
    end else begin
      if (!s_loaded_q) begin
        ssh_q <= tx_have ? tx_head : 8'h00;
        sdo_q <= tx_have ? tx_head[7] : 1'b0;
        s_loaded_q <= 1'b1;
      end else if (s_sample) begin
        ssh_q <= {ssh_q[6:0], mosi_s}; // RL3 RL9
        sbit_q <= s_done ? '0 : sbit_q + 1'b1;
        if (s_done) s_loaded_q <= 1'b0;
      end else if (sck_edge && !(cpha == 1'b0 && sbit_q == '0 && lead_edge)) begin
        sdo_q <= ssh_q[7]; // RL3
      end
    end
  end
  assign tx_pop       = (m_done || (slave_sel && !s_loaded_q)) && tx_have;
  assign rx_push      = m_done || s_done;
  // With phase set, the master's last bit is shifted in on the same tick as the push
  assign rx_push_word = m_done ? (cpha ? {msh_q[6:0], miso_s} : msh_q) : {ssh_q[6:0], mosi_s};

  // ----------------------------------------
  // Pin drivers and error flag
  // ----------------------------------------
  logic mst_boot;
  assign mst_boot = (strap2_q == `SPC_BOOT_MASTER);
  // Clock and master-out drive enables have no async reset: their reset value depends on the straps.
  // Limitation: master boot drive starts a few clocks after reset falls.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serial_bit_clock_pin_oe <= mst_boot; // RL5 RL6
      mosi_oe                 <= mst_boot; // RL5 RL6
    end else begin
      serial_bit_clock_pin_oe <= port_en && is_master; // RL1
      mosi_oe                 <= port_en && is_master; // RL9
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_bit_clock_pin_o  <= 1'b1; // RL6
      mosi_o  <= 1'b0; // RL6
      miso_o  <= 1'b0;
      miso_oe <= 1'b0; // RL5
      pullup_en <= 1'b1; // RL5
      busy <= 1'b0;
    end else begin
      pullup_en <= 1'b1;
      busy <= (st_q != spi_port_pkg::ST_IDLE) || s_loaded_q;
      serial_bit_clock_pin_o  <= sck_q;
      mosi_o  <= mdo_q;
      miso_o  <= od_sel ? 1'b0 : sdo_q; // RL10
      miso_oe <= slave_sel && !slv_tx_dis && (od_sel ? !sdo_q : 1'b1); // RL9 RL10 RL11
    end
  end
  logic mm_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) mm_q <= 1'b0;
    else mm_q <= port_en && is_master && !ss_n_s; // RL8
  end
  assign multimaster_error = mm_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  mm_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
    (port_en && is_master && !ss_n_s) |=> multimaster_error) else $error("multimaster not flagged");
  slave_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL2
    (ss_n_s && !is_master) |-> !s_sample) else $error("slave reacted while deselected");
  sck_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
    (st_q == spi_port_pkg::ST_IDLE) |=> (sck_q == $past(cpol))) else $error("clock not idle");
  miso_dis_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL11
    slv_tx_dis |=> !miso_oe) else $error("miso driven while disabled");
  od_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL10
    (od_sel && miso_oe) |-> !miso_o) else $error("open drain drove high");
  mosi_role_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL9
    (rst_n && !is_master) |=> !mosi_oe) else $error("slave drove mosi");
  word_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
    $rose(st_q == spi_port_pkg::ST_LEAD) && $past(st_q == spi_port_pkg::ST_IDLE) |-> !rx_push [*2])
    else $error("word ended early");
  boot_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL14
    $rose(boot_caught_q) |-> (boot_mode == $past(boot_select_straps))) else $error("boot decode");
endmodule : spi_port
`default_nettype wire

// [spi_port_cfg.svh]
// Constants for the serial peripheral port and boot strap decode
// Summary of operation
// (RL1) Master toggles bit clock once per bit, idle outside each word.
// (RL2) Slave ignores bit clock while slave select is high.
// (RL3) Data launched on one clock edge, sampled on the opposite edge.
// (RL4) Polarity and phase control bits select the transfer format.
// (RL5) Outside master boot, clock and data pins float with pull-ups in reset.
// (RL6) In master boot, clock driven high and master-out low during reset.
// (RL7) Slave select is active low and acts as chip select.
// (RL8) Slave select low while master flags a multimaster error.
// (RL9) Master sends on master-out, slave sends on master-in.
// (RL10) Open-drain bit makes the master-in driver open-drain.
// (RL11) Control bit 5 disables the slave transmit driver on master-in.
// (RL12) System ensures only one slave drives master-in at a time.
// (RL13) Single-master system holds master's own slave select high.
// (RL14) Straps decode 00 slave boot, 01 master boot, 10 parallel boot, 11 reserved.
// (RL15) Board sets strap levels before reset is asserted.
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH
`define SPC_WORD_BITS       8
`define SPC_CNT_W           4
`define SPC_DIV_W           8
`define SPC_CTL_W           8
`define SPC_CTL_RESET       8'h00
`define SPC_BIT_MASTER      0
`define SPC_BIT_CPOL        1
`define SPC_BIT_CPHA        2
`define SPC_BIT_OPEN_DRAIN  3
`define SPC_BIT_ENABLE      4
`define SPC_BIT_SLV_TX_DIS  5
`define SPC_BOOT_SLAVE      2'h0
`define SPC_BOOT_MASTER     2'h1
`define SPC_BOOT_PARALLEL   2'h2
`define SPC_BOOT_RESERVED   2'h3
`endif

// [spi_port_pkg.sv]
// Types for the serial peripheral port
package spi_port_pkg;
  typedef enum logic [1:0] {
    BOOT_SPI_SLAVE    = 2'h0,
    BOOT_SPI_MASTER   = 2'h1,
    BOOT_PARALLEL     = 2'h2,
    BOOT_RESERVED     = 2'h3
  } boot_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LEAD = 3'h2,
    ST_TRAIL = 3'h4
  } mst_state_t;
  typedef struct packed {
    logic       out;
    logic       oe;
  } pin_drv_t;
  typedef struct packed {
    logic [7:0] data;
  } word_t;
endpackage : spi_port_pkg

// [spi_far_slave.sv]
// Far-side serial slave model: replies with a word, captures the word received
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic            miso_oe,
  output logic [7:0]      got
);
  logic [7:0] sh;
  int         cnt;
  // Released line is left to the pull-up on the board
  assign miso_oe = !sel_n;
  always @(negedge sel_n) begin
    sh = reply;
    cnt = 0;
    miso = reply[7];
  end
  always @(sck) begin
    if (!sel_n) begin
      if ((sck != cpol) ^ cpha) begin
        got = {got[6:0], mosi};
        cnt++;
        // Reload so back-to-back words need no reselect
        if (cnt == 8) begin
          sh = reply;
          cnt = 0;
        end
      end else if (cpha) begin
        miso = sh[7];
        sh = sh << 1;
      end else begin
        if (cnt != 0) sh = sh << 1;
        miso = sh[7];
      end
    end
  end
endmodule : spi_far_slave
`default_nettype wire

// [spi_port_bench.sv]
// Self-checking bench for the serial port: boot, master, buffer and slave
`timescale 1ns/1ps
`default_nettype none
module spi_port_bench;
  logic                     sys_clk, rst_n, tx_valid, rx_ready, ss_n, far_sel_n;
  logic [1:0]               boot_select_straps;
  logic [7:0]               ctl, clk_div, reply, q;
  spi_port_pkg::word_t      tx_word, rx_word;
  spi_port_pkg::boot_mode_t boot_mode;
  logic                     tx_ready, rx_valid, multimaster_error, busy, pullup_en;
  logic                     sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic                     bsck, bmosi, far_miso, far_oe, oe_seen, od_bad;
  logic [7:0]               far_got;
  int                       num_errors, total_checks;
  wire sck_w  = sck_oe ? sck_o : bsck;
  wire mosi_w = mosi_oe ? mosi_o : bmosi;
  wire miso_w = miso_oe ? miso_o : (far_oe ? far_miso : 1'b1);

  spi_port u_dut (
    .sys_clk, .rst_n, .boot_select_straps, .serial_port_control_register(ctl), .clk_div,
    .tx_valid, .tx_word, .tx_ready, .rx_valid, .rx_word, .rx_ready, .multimaster_error,
    .boot_mode, .busy, .serial_bit_clock_pin_i(sck_w), .serial_bit_clock_pin_o(sck_o),
    .serial_bit_clock_pin_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .slave_select_input_n(ss_n), .pullup_en
  );
  spi_far_slave u_far (
    .sck(sck_w), .mosi(mosi_w), .sel_n(far_sel_n), .cpol(ctl[1]), .cpha(ctl[2]),
    .reply(reply), .miso(far_miso), .miso_oe(far_oe), .got(far_got)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic do_reset(input logic [1:0] b);
    boot_select_straps <= b;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    settle(12);
    check("reset_oe", 8'({sck_oe, mosi_oe, miso_oe}), {5'h00, b == 2'h1, b == 2'h1, 1'b0});
    check("reset_lvl", 8'({pullup_en, sck_o, mosi_o}), 8'h06);
    @(posedge sys_clk) rst_n <= 1'b1;
    settle(3);
    check("boot_mode", 8'(boot_mode), 8'(b));
  endtask : do_reset
  task automatic push(input logic [7:0] d);
    @(posedge sys_clk) tx_valid <= 1'b1;
    tx_word <= d;
    @(negedge sys_clk);
    for (int i = 0; i < 999 && tx_ready !== 1'b1; i++) @(negedge sys_clk);
    @(posedge sys_clk) tx_valid <= 1'b0;
  endtask : push
  task automatic pop(input logic [7:0] exp);
    @(negedge sys_clk);
    for (int i = 0; i < 999 && rx_valid !== 1'b1; i++) @(negedge sys_clk);
    check("rx_word", rx_word, exp);
    @(posedge sys_clk) rx_ready <= 1'b1;
    @(posedge sys_clk) rx_ready <= 1'b0;
  endtask : pop
  task automatic mst(input logic [7:0] d, input logic [7:0] rep);
    reply = rep;
    far_sel_n <= 1'b0;
    push(d);
    pop(rep);
    check("far_got", far_got, d);
    check("sck_idle", 8'(sck_w), 8'(ctl[1]));
    check("pin_oe", 8'({sck_oe, mosi_oe, miso_oe}), 8'h06);
    @(posedge sys_clk) far_sel_n <= 1'b1;
  endtask : mst
  // Link clock of 64 ns made here, running only inside the frame
  task automatic slv(input logic [7:0] d, input logic sel);
    oe_seen = 1'b0;
    od_bad = 1'b0;
    @(negedge sys_clk) ss_n <= !sel;
    #64;
    for (int i = 7; i >= 0; i--) begin
      bmosi <= d[i];
      #32 bsck <= 1'b1;
      #1 q[i] = miso_w;
      oe_seen |= miso_oe;
      od_bad |= miso_oe & miso_o;
      #31 bsck <= 1'b0;
    end
    #64 ss_n <= 1'b1;
    bmosi <= 1'b1;
  endtask : slv

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    rst_n <= 1'b0;
    boot_select_straps <= 2'h0;
    ctl <= 8'h00;
    clk_div <= 8'h07;
    tx_valid <= 1'b0;
    tx_word <= 8'h00;
    rx_ready <= 1'b0;
    ss_n <= 1'b1;
    far_sel_n <= 1'b1;
    bsck <= 1'b0;
    bmosi <= 1'b1;
    reply = 8'h00;
    for (int b = 0; b < 4; b++) do_reset(2'(b));
    $display("test boot done");
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk) ctl <= 8'h11 | (8'(m) << 1);
      settle(4);
      mst(8'h96 ^ 8'(m), 8'h3c + 8'(m));
    end
    $display("test master modes done");
    @(posedge sys_clk) ss_n <= 1'b0;
    settle(5);
    check("mm_err", 8'(multimaster_error), 8'h01);
    @(posedge sys_clk) ss_n <= 1'b1;
    settle(5);
    check("mm_err", 8'(multimaster_error), 8'h00);
    $display("test multimaster done");
    reply = 8'h5a;
    far_sel_n <= 1'b0;
    push(8'ha1);
    push(8'ha2);
    push(8'ha3);
    settle(400);
    check("busy_full", 8'({rx_valid, busy}), 8'h02);
    for (int i = 0; i < 3; i++) pop(8'h5a);
    check("far_got", far_got, 8'ha3);
    @(posedge sys_clk) far_sel_n <= 1'b1;
    $display("test buffer done");
    @(posedge sys_clk) ctl <= 8'h10;
    push(8'hc3);
    slv(8'h69, 1'b1);
    check("slv_tx", q, 8'hc3);
    check("slv_oe", 8'({oe_seen, multimaster_error}), 8'h02);
    pop(8'h69);
    @(posedge sys_clk) ctl <= 8'h18;
    push(8'h5a);
    slv(8'ha5, 1'b1);
    check("od_tx", q, 8'h5a);
    check("od_high", 8'(od_bad), 8'h00);
    pop(8'ha5);
    @(posedge sys_clk) ctl <= 8'h30;
    push(8'h0f);
    slv(8'h33, 1'b1);
    check("dis_oe", 8'(oe_seen), 8'h00);
    pop(8'h33);
    slv(8'hff, 1'b0);
    settle(10);
    check("unsel_rx", 8'({rx_valid, oe_seen}), 8'h00);
    $display("test slave done");
    end_of_test();
  end

  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule : spi_port_bench
`default_nettype wire
